// ==== include/sps_params.svh ====
// Constants of the SPI slave controller
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH

`define SPS_MODE_SPI 3'h2
`define SPS_BUSY_TOKEN 8'hFF
`define SPS_FIFO_DEPTH 4
`define SPS_DATA_W 8
`define SPS_CNT_W 16
`define SPS_CLK_KHZ 25000
`define SPS_MAX_RATE_KBPS 5000
`define SPS_MIN_HALF_CYC ((`SPS_CLK_KHZ + 2 * `SPS_MAX_RATE_KBPS - 1) / (2 * `SPS_MAX_RATE_KBPS))
`define SPS_IRQ_N 9
`define SPS_IRQ_TXIDLE 0
`define SPS_IRQ_TXSPACE 1
`define SPS_IRQ_RXVAL 2
`define SPS_IRQ_TXDMA_A 3
`define SPS_IRQ_TXDMA_B 4
`define SPS_IRQ_RXDMA_A 5
`define SPS_IRQ_RXDMA_B 6
`define SPS_IRQ_RXOVR 7
`define SPS_IRQ_TXUND 8
`define SPS_SEL_SAVED_A 0
`define SPS_SEL_SAVED_B 1
`define SPS_SEL_EXTRA 2
`define SPS_RESET_CFG 8'h00

`endif

// ==== include/sps_pkg.sv ====
// Types of the SPI slave controller
package sps_pkg;

  typedef struct packed {
    logic [2:0] serial_mode_select;
    logic master_select_bit;
    logic underrun_repeat_bit;
    logic bit_order_bit;
    logic clock_phase_bit;
    logic clock_polarity_bit;
  } sps_cfg_s;

  typedef struct packed {
    logic tx_all_idle;
    logic tx_fifo_has_space;
    logic rx_fifo_nonempty;
    logic rx_overflow_flag;
  } sps_stat_s;

  typedef enum logic [1:0] {
    SPS_LNK_OFF = 2'b00,
    SPS_LNK_WAIT = 2'b01,
    SPS_LNK_SEL = 2'b11
  } sps_lnk_e;

endpackage : sps_pkg

// ==== hw/sps_fifo.sv ====
// Flip-flop FIFO used for transmit and receive characters
`timescale 1ns/1ps
module sps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic push_valid,
  output logic push_ready,
  input wire logic [WIDTH-1:0] push_data,
  output logic pop_valid,
  input wire logic pop_ready,
  output logic [WIDTH-1:0] pop_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic do_push;
  logic do_pop;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : nxt

  assign push_ready = (cnt_q != (AW + 1)'(DEPTH));
  assign pop_valid = (cnt_q != '0);
  assign pop_data = mem_q[rd_q];
  assign do_push = push_valid && push_ready;
  assign do_pop = pop_valid && pop_ready;

  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem_q[wr_q] <= push_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= nxt(wr_q);
      end
      if (do_pop) begin
        rd_q <= nxt(rd_q);
      end
      if (do_push && !do_pop) begin
        cnt_q <= cnt_q + (AW + 1)'(1);
      end else if (do_pop && !do_push) begin
        cnt_q <= cnt_q - (AW + 1)'(1);
      end
    end
  end

  a_fifo_never_over: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cnt_q <= (AW + 1)'(DEPTH)) else $error("fifo count above depth");
endmodule : sps_fifo

// ==== hw/sps_top.sv ====
// SPI slave controller: link engine, FIFOs, status, DMA count save, interrupts
// Function
// - Slave operates only when mode select is 2 and master bit is 0.
// - Bit clock comes only from external master, at most 5 Mbps.
// - Bit order bit: 0 sends MSB first, 1 sends LSB first, both directions.
// - Phase: sample first edge or second; polarity: rising or falling leading edge.
// - Shift in MOSI and drive MISO only while select is asserted.
// - Select falling edge clears receive shift register and loads transmit shift register.
// - Separate four-entry FIFOs; data port write pushes, read pops.
// - DMA channels push and pop the FIFOs like data port accesses.
// - Received characters go to receive FIFO; nonempty flag shows data available.
// - Character arriving on full receive FIFO is dropped, sets overflow and interrupt.
// - DMA overrun shown only after FIFO drains; cleared by reset bit or load.
// - Each received character is matched by one transmitted character.
// - Empty transmit FIFO when due: underrun flag, send last or 0xFF.
// - Write into idle transmitter clears idle flag; set again when all shifted.
// - Space flag clears when FIFO full, sets when character moves out.
// - After first receive within select, pad byte precedes data into empty FIFO.
// - First select rise after buffer load saves running count; later rises only flag.
// - Three-bit record shows which buffer count was saved and extra rises.
// - Idle, space and valid interrupts fire on rise or level per mode.
// - DMA buffer complete interrupts fire on falling buffer-active flags.
// - Receive overrun and transmit underrun also raise interrupt events.
// - Interrupt reaches processor only with second-level and top-level enables set.
`timescale 1ns/1ps
`include "sps_params.svh"
module sps_top #(
  parameter int DATA_W = `SPS_DATA_W,
  parameter int DEPTH = `SPS_FIFO_DEPTH,
  parameter int CNT_W = `SPS_CNT_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sclk_in,
  input wire logic mosi_in,
  input wire logic slave_select_n,
  output logic miso_out,
  output logic miso_oe,
  input wire sps_pkg::sps_cfg_s spi_config_reg,
  output sps_pkg::sps_stat_s spi_status_reg,
  input wire logic data_port_wr,
  input wire logic [DATA_W-1:0] data_port_wdata,
  output logic data_port_wr_ready,
  input wire logic data_port_rd,
  output logic [DATA_W-1:0] data_port_rdata,
  output logic data_port_rvalid,
  input wire logic tx_dma_valid,
  input wire logic [DATA_W-1:0] tx_dma_data,
  output logic tx_dma_ready,
  input wire logic rx_dma_enable,
  input wire logic rx_dma_pop,
  output logic rx_dma_pop_ready,
  output logic [DATA_W-1:0] rx_dma_data,
  input wire logic [1:0] dma_channel_reset,
  input wire logic [1:0] rx_dma_load,
  input wire logic [CNT_W-1:0] rx_dma_count_a,
  input wire logic [CNT_W-1:0] rx_dma_count_b,
  input wire logic rx_dma_buf_sel,
  input wire logic [1:0] tx_buffer_active,
  input wire logic [1:0] rx_buffer_active,
  output logic [CNT_W-1:0] saved_rx_count,
  output logic [2:0] select_edge_record,
  output logic rx_dma_overrun,
  input wire logic irq_mode_select,
  input wire logic [`SPS_IRQ_N-1:0] irq_enable_reg,
  input wire logic top_irq_enable,
  input wire logic [`SPS_IRQ_N-1:0] irq_flag_clear,
  output logic [`SPS_IRQ_N-1:0] irq_flag_reg,
  output logic irq_out
);
  // ****************************************
  // Reset and input synchronisers
  // ****************************************
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [2:0] sclk_q;
  logic [1:0] mosi_q;
  logic [2:0] ssn_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 3'h0;
      mosi_q <= 2'h0;
      ssn_q <= 3'h7;
    end else begin
      sclk_q <= {sclk_q[1:0], sclk_in};
      mosi_q <= {mosi_q[0], mosi_in};
      ssn_q <= {ssn_q[1:0], slave_select_n};
    end
  end

  // ****************************************
  // Link edge decode
  // ****************************************
  logic active;
  logic sel;
  logic sel_fall;
  logic sel_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic lead_edge;
  logic trail_edge;
  logic sample_edge;
  logic shift_edge;
  sps_pkg::sps_lnk_e lnk_q;

  assign active = (spi_config_reg.serial_mode_select == `SPS_MODE_SPI) &&
                  !spi_config_reg.master_select_bit;
  assign sel = !ssn_q[1];
  assign sel_fall = ssn_q[2] && !ssn_q[1];
  assign sel_rise = !ssn_q[2] && ssn_q[1];
  assign sclk_rise = !sclk_q[2] && sclk_q[1];
  assign sclk_fall = sclk_q[2] && !sclk_q[1];
  assign lead_edge = spi_config_reg.clock_polarity_bit ? sclk_fall : sclk_rise;
  assign trail_edge = spi_config_reg.clock_polarity_bit ? sclk_rise : sclk_fall;
  assign sample_edge = (lnk_q == sps_pkg::SPS_LNK_SEL) &&
                       (spi_config_reg.clock_phase_bit ? trail_edge : lead_edge);
  assign shift_edge = (lnk_q == sps_pkg::SPS_LNK_SEL) &&
                      (spi_config_reg.clock_phase_bit ? lead_edge : trail_edge);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lnk_q <= sps_pkg::SPS_LNK_OFF;
    end else begin
      unique case (lnk_q)
        sps_pkg::SPS_LNK_OFF: begin
          if (active) begin
            lnk_q <= sps_pkg::SPS_LNK_WAIT;
          end
        end
        sps_pkg::SPS_LNK_WAIT: begin
          if (!active) begin
            lnk_q <= sps_pkg::SPS_LNK_OFF;
          end else if (sel_fall) begin
            lnk_q <= sps_pkg::SPS_LNK_SEL;
          end
        end
        sps_pkg::SPS_LNK_SEL: begin
          if (!active) begin
            lnk_q <= sps_pkg::SPS_LNK_OFF;
          end else if (!sel) begin
            lnk_q <= sps_pkg::SPS_LNK_WAIT;
          end
        end
        default: begin
          lnk_q <= sps_pkg::SPS_LNK_OFF;
        end
      endcase
    end
  end

  // ****************************************
  // FIFOs and their sources
  // ****************************************
  logic tx_push_valid;
  logic tx_push_ready;
  logic [DATA_W-1:0] tx_push_data;
  logic tx_pop_valid;
  logic tx_pop;
  logic [DATA_W-1:0] tx_pop_data;
  logic rx_push;
  logic rx_push_ready;
  logic rx_pop_valid;
  logic rx_pop;
  logic [DATA_W-1:0] rx_pop_data;
  logic [DATA_W-1:0] rx_shift_q;
  logic [3:0] bit_cnt_q;
  logic byte_done;

  // Software data port has priority over DMA on both FIFOs
  assign tx_push_valid = data_port_wr || tx_dma_valid;
  assign tx_push_data = data_port_wr ? data_port_wdata : tx_dma_data;
  assign data_port_wr_ready = tx_push_ready;
  assign tx_dma_ready = tx_push_ready && !data_port_wr;
  assign rx_pop = rx_pop_valid && (data_port_rd || rx_dma_pop);
  assign rx_dma_pop_ready = rx_pop_valid && !data_port_rd;
  assign rx_dma_data = rx_pop_data;
  assign byte_done = sample_edge && (bit_cnt_q == 4'h7);
  assign rx_push = byte_done && rx_push_ready;

  sps_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .push_valid(tx_push_valid),
    .push_ready(tx_push_ready),
    .push_data(tx_push_data),
    .pop_valid(tx_pop_valid),
    .pop_ready(tx_pop),
    .pop_data(tx_pop_data)
  );

  sps_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .push_valid(rx_push),
    .push_ready(rx_push_ready),
    .push_data(sps_next_rx(rx_shift_q, mosi_q[1], spi_config_reg.bit_order_bit)),
    .pop_valid(rx_pop_valid),
    .pop_ready(rx_pop),
    .pop_data(rx_pop_data)
  );

  function automatic logic [DATA_W-1:0] sps_next_rx(input logic [DATA_W-1:0] s, input logic b,
                                                    input logic lsb_first);
    sps_next_rx = lsb_first ? {b, s[DATA_W-1:1]} : {s[DATA_W-2:0], b};
  endfunction : sps_next_rx

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_port_rdata <= '0;
      data_port_rvalid <= 1'b0;
    end else begin
      data_port_rvalid <= data_port_rd && rx_pop_valid;
      if (data_port_rd && rx_pop_valid) begin
        data_port_rdata <= rx_pop_data;
      end
    end
  end

  // ****************************************
  // Receive and transmit shifters
  // ****************************************
  logic [DATA_W-1:0] tx_shift_q;
  logic [DATA_W-1:0] last_tx_q;
  logic first_q;
  logic pad_armed_q;
  logic pad_pend_q;
  logic tx_busy_q;
  logic load_due;
  logic underrun;
  logic [DATA_W-1:0] fill_byte;

  assign load_due = ((lnk_q == sps_pkg::SPS_LNK_WAIT) && sel_fall) || byte_done;
  assign fill_byte = spi_config_reg.underrun_repeat_bit ? last_tx_q : `SPS_BUSY_TOKEN;
  assign tx_pop = load_due && !pad_pend_q && tx_pop_valid;
  assign underrun = load_due && !pad_pend_q && !tx_pop_valid;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift_q <= '0;
      bit_cnt_q <= 4'h0;
    end else if ((lnk_q == sps_pkg::SPS_LNK_WAIT) && sel_fall) begin
      rx_shift_q <= '0;
      bit_cnt_q <= 4'h0;
    end else if (sample_edge) begin
      rx_shift_q <= sps_next_rx(rx_shift_q, mosi_q[1], spi_config_reg.bit_order_bit);
      bit_cnt_q <= byte_done ? 4'h0 : bit_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift_q <= '0;
      last_tx_q <= '0;
      first_q <= 1'b0;
      tx_busy_q <= 1'b0;
    end else if (load_due) begin
      // Reload on a sample edge keeps the new first bit over the next shift edge
      first_q <= spi_config_reg.clock_phase_bit || byte_done;
      if (pad_pend_q) begin
        tx_shift_q <= fill_byte;
      end else if (tx_pop_valid) begin
        tx_shift_q <= tx_pop_data;
        last_tx_q <= tx_pop_data;
        tx_busy_q <= 1'b1;
      end else begin
        tx_shift_q <= fill_byte;
        tx_busy_q <= 1'b0;
      end
    end else if (shift_edge) begin
      if (first_q) begin
        first_q <= 1'b0;
      end else if (spi_config_reg.bit_order_bit) begin
        tx_shift_q <= {1'b0, tx_shift_q[DATA_W-1:1]};
      end else begin
        tx_shift_q <= {tx_shift_q[DATA_W-2:0], 1'b0};
      end
    end else if (lnk_q != sps_pkg::SPS_LNK_SEL) begin
      tx_busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      miso_out <= spi_config_reg.bit_order_bit ? tx_shift_q[0] : tx_shift_q[DATA_W-1];
      miso_oe <= (lnk_q == sps_pkg::SPS_LNK_SEL) && sel;
    end
  end

  // Padding arms once the receive FIFO holds a character during a selection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pad_armed_q <= 1'b0;
      pad_pend_q <= 1'b0;
    end else if (lnk_q != sps_pkg::SPS_LNK_SEL) begin
      pad_armed_q <= 1'b0;
      pad_pend_q <= 1'b0;
    end else begin
      if (rx_pop_valid) begin
        pad_armed_q <= 1'b1;
      end
      if (pad_armed_q && !tx_pop_valid && tx_push_valid && tx_push_ready) begin
        pad_pend_q <= 1'b1;
      end else if (load_due) begin
        pad_pend_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  logic ovf_q;
  logic idle_q;
  logic space_q;
  logic rx_drop;

  assign rx_drop = byte_done && !rx_push_ready;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ovf_q <= 1'b0;
      idle_q <= 1'b1;
      space_q <= 1'b1;
    end else begin
      if (rx_drop) begin
        ovf_q <= 1'b1;
      end else if (data_port_rd) begin
        ovf_q <= 1'b0;
      end
      idle_q <= !tx_pop_valid && !tx_busy_q && !tx_push_valid;
      if (!tx_push_ready) begin
        space_q <= tx_pop;
      end else begin
        space_q <= 1'b1;
      end
    end
  end

  assign spi_status_reg = '{tx_all_idle: idle_q, tx_fifo_has_space: space_q,
                            rx_fifo_nonempty: rx_pop_valid, rx_overflow_flag: ovf_q};

  // ****************************************
  // Receive DMA count save and overrun
  // ****************************************
  logic save_armed_q;
  logic ovr_pend_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      save_armed_q <= 1'b0;
      saved_rx_count <= '0;
      select_edge_record <= 3'h0;
    end else if (rx_dma_load != 2'h0) begin
      save_armed_q <= 1'b1;
      select_edge_record <= 3'h0;
    end else if (rx_dma_enable && sel_rise) begin
      if (save_armed_q) begin
        save_armed_q <= 1'b0;
        saved_rx_count <= rx_dma_buf_sel ? rx_dma_count_b : rx_dma_count_a;
        select_edge_record[`SPS_SEL_SAVED_B] <= rx_dma_buf_sel;
        select_edge_record[`SPS_SEL_SAVED_A] <= !rx_dma_buf_sel;
      end else begin
        select_edge_record[`SPS_SEL_EXTRA] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ovr_pend_q <= 1'b0;
      rx_dma_overrun <= 1'b0;
    end else begin
      if (rx_drop && rx_dma_enable) begin
        ovr_pend_q <= 1'b1;
      end else if (!rx_pop_valid) begin
        ovr_pend_q <= 1'b0;
      end
      if (ovr_pend_q && !rx_pop_valid) begin
        rx_dma_overrun <= 1'b1;
      end else if (dma_channel_reset[1] || (rx_dma_load != 2'h0)) begin
        rx_dma_overrun <= 1'b0;
      end
    end
  end

  // ****************************************
  // Interrupt events
  // ****************************************
  logic [2:0] lvl_prev_q;
  logic [1:0] txact_prev_q;
  logic [1:0] rxact_prev_q;
  logic [2:0] lvl_now;
  logic [`SPS_IRQ_N-1:0] irq_event;

  assign lvl_now = {rx_pop_valid, space_q, idle_q};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lvl_prev_q <= 3'h0;
      txact_prev_q <= 2'h0;
      rxact_prev_q <= 2'h0;
    end else begin
      lvl_prev_q <= lvl_now;
      txact_prev_q <= tx_buffer_active;
      rxact_prev_q <= rx_buffer_active;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[`SPS_IRQ_RXVAL:`SPS_IRQ_TXIDLE] = irq_mode_select ? lvl_now : lvl_now & ~lvl_prev_q;
    irq_event[`SPS_IRQ_TXDMA_B:`SPS_IRQ_TXDMA_A] = txact_prev_q & ~tx_buffer_active;
    irq_event[`SPS_IRQ_RXDMA_B:`SPS_IRQ_RXDMA_A] = rxact_prev_q & ~rx_buffer_active;
    irq_event[`SPS_IRQ_RXOVR] = rx_drop;
    irq_event[`SPS_IRQ_TXUND] = underrun;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_flag_reg <= '0;
      irq_out <= 1'b0;
    end else begin
      irq_flag_reg <= (irq_flag_reg & ~irq_flag_clear) | irq_event;
      irq_out <= top_irq_enable && ((irq_flag_reg & irq_enable_reg) != '0);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_byte_end;
    byte_done;
  endsequence
  sequence s_drop;
    byte_done && !rx_push_ready;
  endsequence

  a_slave_gate_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !active |=> lnk_q == sps_pkg::SPS_LNK_OFF) else $error("link active outside slave mode");
  a_miso_only_sel: assert property (@(posedge clk_sys) disable iff (!rst_n)
    miso_oe |-> $past(sel)) else $error("miso driven without select");
  a_sel_fall_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (lnk_q == sps_pkg::SPS_LNK_WAIT && sel_fall) |=> bit_cnt_q == 4'h0 && rx_shift_q == '0)
    else $error("shifters not cleared at select");
  a_drop_sets_ovf: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_drop |=> ovf_q && irq_flag_reg[`SPS_IRQ_RXOVR]) else $error("drop without overflow");
  a_lockstep_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_byte_end |-> (tx_pop || underrun || pad_pend_q)) else $error("byte without tx char");
  a_underrun_fill: assert property (@(posedge clk_sys) disable iff (!rst_n)
    underrun && !spi_config_reg.underrun_repeat_bit |=> tx_shift_q == `SPS_BUSY_TOKEN)
    else $error("underrun fill wrong");
  a_full_space_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!tx_push_ready && !tx_pop) |=> !space_q) else $error("space flag high while full");
  a_irq_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq_out |-> $past(top_irq_enable)) else $error("irq without top enable");
  a_save_once: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rx_dma_enable && sel_rise && !save_armed_q && rx_dma_load == 2'h0) |=>
    $stable(saved_rx_count) && select_edge_record[`SPS_SEL_EXTRA]) else $error("count resaved");
endmodule : sps_top

// ==== tb/sps_master_model.sv ====
// Behavioural SPI master facing the slave under test
`timescale 1ns/1ps
module sps_master_model #(
  parameter int HALF_NS = 160
) (
  output logic sclk,
  output logic mosi,
  output logic ssel_n,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    ssel_n = 1'b1;
  end
  // Clock parked at idle level, then select pulled low
  task automatic sel(input logic [2:0] fmt);
    sclk = fmt[0];
    #(HALF_NS + 13) ssel_n = 1'b0;
    #(2 * HALF_NS);
  endtask : sel
  // Released data line shows the inverse of its last value
  task automatic desel();
    #(HALF_NS) ssel_n = 1'b1;
    mosi = ~mosi;
  endtask : desel
  // Format is lsb first, phase, polarity; 320 ns per bit stays under 5 Mbps
  task automatic xfer(input logic [7:0] tx, input logic [2:0] fmt, output logic [7:0] rx);
    int b;
    for (int i = 0; i < 8; i++) begin
      b = fmt[2] ? i : 7 - i;
      if (fmt[1]) sclk = ~fmt[0];
      mosi = tx[b];
      // Sample at the sampling edge, before the slave reacts to it
      #(HALF_NS) rx[b] = miso;
      sclk = fmt[1] ? fmt[0] : ~fmt[0];
      #(HALF_NS);
      if (!fmt[1]) sclk = fmt[0];
    end
  endtask : xfer
endmodule : sps_master_model

// ==== tb/sps_top_bench.sv ====
// Self-checking bench of the SPI slave controller
`timescale 1ns/1ps
`include "sps_params.svh"
module sps_top_bench;
  logic clk_sys, rst_b, sclk, mosi, ssel_n, miso_out, miso_oe, miso_last, miso_line;
  logic wr, rd, rvalid, wr_ready, txd_valid, txd_ready, rxd_en, rxd_pop, rxd_ready, sel_buf;
  logic irq_mode, top_en, irq_out, dma_ovr;
  logic [7:0] wdata, rdata, txd_data, rxd_data, got;
  logic [1:0] chan_rst, load, tx_act, rx_act;
  logic [15:0] cnt_a, cnt_b, saved;
  logic [2:0] rec;
  logic [`SPS_IRQ_N-1:0] irq_en, irq_clr, irq_flag;
  sps_pkg::sps_cfg_s cfg;
  sps_pkg::sps_stat_s stat;
  int miscompares, num_checks;
  // ****************************************
  // Design and partner
  // ****************************************
  sps_top u_sps_top (
    .clk_sys(clk_sys), .rst_b(rst_b), .sclk_in(sclk), .mosi_in(mosi), .slave_select_n(ssel_n),
    .miso_out(miso_out), .miso_oe(miso_oe), .spi_config_reg(cfg), .spi_status_reg(stat),
    .data_port_wr(wr), .data_port_wdata(wdata), .data_port_wr_ready(wr_ready), .data_port_rd(rd),
    .data_port_rdata(rdata), .data_port_rvalid(rvalid), .tx_dma_valid(txd_valid), .tx_dma_data(txd_data),
    .tx_dma_ready(txd_ready), .rx_dma_enable(rxd_en), .rx_dma_pop(rxd_pop), .rx_dma_pop_ready(rxd_ready),
    .rx_dma_data(rxd_data), .dma_channel_reset(chan_rst), .rx_dma_load(load), .rx_dma_count_a(cnt_a),
    .rx_dma_count_b(cnt_b), .rx_dma_buf_sel(sel_buf), .tx_buffer_active(tx_act), .rx_buffer_active(rx_act),
    .saved_rx_count(saved), .select_edge_record(rec), .rx_dma_overrun(dma_ovr), .irq_mode_select(irq_mode),
    .irq_enable_reg(irq_en), .top_irq_enable(top_en), .irq_flag_clear(irq_clr), .irq_flag_reg(irq_flag),
    .irq_out(irq_out));
  sps_master_model u_m (.sclk(sclk), .mosi(mosi), .ssel_n(ssel_n), .miso(miso_line));
  always @(posedge clk_sys) if (miso_oe) miso_last <= miso_out;
  assign miso_line = miso_oe ? miso_out : ~miso_last;
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // ****************************************
  // Tasks and tests
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  task automatic put(input logic [7:0] d);
    @(negedge clk_sys);
    wr = 1'b1;
    wdata = d;
    @(negedge clk_sys);
    wr = 1'b0;
  endtask : put
  task automatic get(input logic [7:0] exp);
    @(negedge clk_sys);
    rd = 1'b1;
    @(negedge clk_sys);
    rd = 1'b0;
    chk(16'({rvalid, rdata}), 16'({1'b1, exp}));
  endtask : get
  task automatic xchg(input logic [7:0] tx, input logic [7:0] exp, input logic [2:0] fmt);
    u_m.xfer(tx, fmt, got);
    chk(16'(got), 16'(exp));
  endtask : xchg
  task automatic results();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  initial begin
    {wr, rd, txd_valid, rxd_pop, sel_buf, irq_mode, top_en, rst_b} = '0;
    {wdata, txd_data, chan_rst, load, tx_act, rx_act, cnt_b, irq_en, irq_clr} = '0;
    cnt_a = 16'h0123;
    rxd_en = 1'b1;
    cfg = 8'h50;
    tick(12);
    rst_b = 1'b1;
    tick(4);
    chk(16'(stat), 16'h000C);
    u_m.sel(3'h0);
    chk(16'(miso_oe), 16'h0000);
    u_m.xfer(8'h33, 3'h0, got);
    u_m.desel();
    tick(8);
    chk(16'(stat.rx_fifo_nonempty), 16'h0000);
    cfg = 8'h40;
    for (int i = 0; i < 4; i++) put(8'(8'hA1 + i));
    tick(1);
    chk(16'({wr_ready, stat.tx_all_idle, stat.tx_fifo_has_space}), 16'h0000);
    chk(16'(txd_ready), 16'h0000);
    load = 2'b01;
    tick(1);
    load = 2'b00;
    u_m.sel(3'h0);
    chk(16'(miso_oe), 16'h0001);
    for (int i = 0; i < 5; i++) xchg(8'(8'h11 + i), i < 4 ? 8'(8'hA1 + i) : 8'hFF, 3'h0);
    u_m.desel();
    tick(8);
    chk(16'({miso_oe, stat}), 16'h000F);
    chk(16'({irq_flag[8:7], irq_flag[2], dma_ovr}), 16'h000E);
    chk(saved, 16'h0123);
    chk(16'(rec), 16'h0001);
    get(8'h11);
    chk(16'(stat.rx_overflow_flag), 16'h0000);
    get(8'h12);
    get(8'h13);
    tick(1);
    chk(16'({rxd_ready, rxd_data}), 16'h0114);
    rxd_pop = 1'b1;
    tick(1);
    rxd_pop = 1'b0;
    tick(2);
    chk(16'({stat.rx_fifo_nonempty, dma_ovr}), 16'h0001);
    chan_rst = 2'b10;
    tick(1);
    chan_rst = 2'b00;
    tick(2);
    chk(16'(dma_ovr), 16'h0000);
    cnt_a = 16'h0456;
    u_m.sel(3'h0);
    u_m.desel();
    tick(8);
    chk(16'(rec), 16'h0005);
    chk(saved, 16'h0123);
    irq_en = 9'h100;
    tick(3);
    chk(16'(irq_out), 16'h0000);
    top_en = 1'b1;
    tick(3);
    chk(16'(irq_out), 16'h0001);
    irq_clr = '1;
    tick(1);
    irq_clr = '0;
    rx_act = 2'b01;
    tick(2);
    rx_act = 2'b00;
    tick(3);
    chk(16'({irq_flag[8], irq_flag[5]}), 16'h0001);
    irq_mode = 1'b1;
    irq_clr = '1;
    tick(1);
    irq_clr = '0;
    irq_mode = 1'b0;
    chk(16'(irq_flag[2:0]), 16'h0003);
    cfg = 8'h47;
    u_m.sel(3'h7);
    xchg(8'h3C, 8'hFF, 3'h7);
    tick(10);
    put(8'h5A);
    xchg(8'h81, 8'hFF, 3'h7);
    xchg(8'h96, 8'hFF, 3'h7);
    xchg(8'hC3, 8'h5A, 3'h7);
    u_m.desel();
    get(8'h3C);
    get(8'h81);
    get(8'h96);
    get(8'hC3);
    cfg = 8'h48;
    tick(2);
    txd_valid = 1'b1;
    txd_data = 8'h77;
    tick(1);
    txd_valid = 1'b0;
    u_m.sel(3'h0);
    xchg(8'h00, 8'h77, 3'h0);
    xchg(8'h00, 8'h77, 3'h0);
    u_m.desel();
    tick(8);
    results();
  end
  initial begin
    #200000;
    miscompares++;
    results();
  end
endmodule : sps_top_bench
